// ===== rtl/crsd_map.svh
// Offsets, field positions, reset values and timing counts for the strap decoder
`ifndef CRSD_MAP_SVH
`define CRSD_MAP_SVH
`define CRSD_REG_RATIO 4'h0
`define CRSD_REG_CTRL 4'h4
`define CRSD_REG_STATUS 4'h8
`define CRSD_REG_STRAPS 4'hc
`define CRSD_CTRL_RESET 32'h0000_0000
`define CRSD_PLAT_RESERVED 5'h00
`define CRSD_CORE_HALVES_BIT 0
`define CRSD_STAT_LATCHED_BIT 0
`define CRSD_STAT_RSVD_BIT 1
`define CRSD_STAT_PCI64_BIT 2
`define CRSD_STAT_CFGRST_BIT 3
`define CRSD_RESET_HOLD_NS 1000
`define CRSD_CLK_PERIOD_NS 100
`define CRSD_RESET_HOLD_CYC ((`CRSD_RESET_HOLD_NS + `CRSD_CLK_PERIOD_NS - 1) / `CRSD_CLK_PERIOD_NS)
`endif

// ===== rtl/crsd_pkg.sv
// Types shared by the clock ratio strap decoder
package crsd_pkg;
  typedef enum logic [1:0] {
    CRSD_ST_RESET,
    CRSD_ST_HOLD,
    CRSD_ST_RUN
  } crsd_state_t;
  typedef logic [4:0] crsd_plat_mult_t;
  typedef logic [2:0] crsd_core_halves_t;
endpackage

// ===== rtl/crsd_sync.sv
// Two flip-flop synchroniser for a bus of strap pin inputs
`timescale 1ns/1ps
module crsd_sync #(
  parameter int WIDTH = 7
) (
  input wire logic clock_i, // System input clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [WIDTH-1:0] async_i, // Raw pin levels
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Pins are asynchronous; second stage alone feeds logic
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule

// ===== rtl/crsd_top.sv
// Reset-time strap sampler and clock ratio decoder with an Avalon-MM register slave
// How it works
// - The four platform ratio strap bits are sampled while reset is held and pick the platform multiplier.
// - The platform code maps 0000 to 16, 0010..0110 to 2..6, 1000/1001/1010 to 8/9/10, 1100 to 12, others reserved.
// - The two core ratio straps give core:platform of 2:1, 5:2, 3:1 or 7:2 for codes 00..11.
// - The L2, DDR data rate and core complex bus clocks all take the one platform ratio.
// - The memory bus clock runs at half the platform clock, half the DDR data rate.
// - Weak pull-ups on configuration pins are enabled only while in the reset state.
// - The PCI width strap is sampled in reset; low selects 64-bit, high selects 32-bit.
// - Designated outputs are driven actively throughout reset, never released.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "crsd_map.svh"
module crsd_top import crsd_pkg::*; #(
  parameter int RESET_HOLD_CYC = `CRSD_RESET_HOLD_CYC
) (
  input wire logic clock_i, // System input clock, 10 MHz
  input wire logic rst_i, // Bus-side synchronous reset
  input wire logic cfg_reset_i, // Device power-up reset pin, high in reset
  input wire logic [3:0] platform_ratio_strap_i, // Platform ratio strap pins
  input wire logic core_ratio_strap_high_i, // Core ratio strap, upper bit
  input wire logic core_ratio_strap_low_i, // Core ratio strap, lower bit
  input wire logic pci_width_strap_i, // PCI width strap, low for 64-bit
  output logic cfg_pullup_en_o, // Weak strap pull-up enable
  output logic reset_drive_en_o, // Output enable of a pin driven in reset
  output logic reset_drive_o, // Level driven on that pin
  output logic [4:0] platform_mult_o, // Platform:system multiplier, 0 if reserved
  output logic [2:0] core_halves_o, // Core:platform ratio in halves (4..7)
  output logic [4:0] l2_mult_o, // L2 clock multiplier
  output logic [4:0] ddr_rate_mult_o, // DDR data rate multiplier
  output logic [4:0] ccb_mult_o, // Core complex bus clock multiplier
  output logic [5:0] mem_bus_mult_x2_o, // Memory bus multiplier, doubled
  output logic pci64_o, // 64-bit PCI selected
  output logic ratio_valid_o, // Ratios latched and not reserved
  input wire logic [3:0] avs_address, // Avalon byte address
  input wire logic avs_read, // Avalon read
  input wire logic avs_write, // Avalon write
  input wire logic [31:0] avs_writedata, // Avalon write data
  input wire logic [3:0] avs_byteenable, // Avalon byte enables
  output logic [31:0] avs_readdata, // Avalon read data
  output logic avs_waitrequest // Avalon wait request
);

  // ****************************************
  // Strap decode functions
  // ****************************************

  // Platform code to multiplier, 0 marks a reserved code
  function automatic crsd_plat_mult_t plat_decode(input logic [3:0] code);
    crsd_plat_mult_t m;
    m = `CRSD_PLAT_RESERVED;
    unique case (code)
      4'h0: m = 5'h10;
      4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc: m = {1'b0, code};
      default: m = `CRSD_PLAT_RESERVED; // Reserved codes
    endcase
    return m;
  endfunction

  // Core code to ratio in halves: 4=2:1, 5=5:2, 6=3:1, 7=7:2
  function automatic crsd_core_halves_t core_decode(input logic [1:0] code);
    return {1'b1, code};
  endfunction

  // ****************************************
  // Pin synchronisation
  // ****************************************

  logic [7:0] pins_raw;
  logic [7:0] pins_s;
  assign pins_raw = {cfg_reset_i, pci_width_strap_i, core_ratio_strap_high_i,
                     core_ratio_strap_low_i, platform_ratio_strap_i};

  crsd_sync #(.WIDTH(8)) u_sync (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins_s)
  );

  wire cfg_rst_s = pins_s[7];
  wire pci_s = pins_s[6];
  wire [1:0] core_s = pins_s[5:4];
  wire [3:0] plat_s = pins_s[3:0];

  // ****************************************
  // Reset-state sequencer
  // ****************************************

  crsd_state_t state_ff;
  crsd_state_t nxt_state;
  logic [15:0] hold_cnt_ff;
  logic [15:0] nxt_hold_cnt;
  logic [3:0] plat_ff;
  logic [1:0] core_ff;
  logic pci_ff;
  logic latched_ff;
  logic [4:0] plat_mult_ff;
  logic [2:0] core_halves_ff;
  logic pci64_ff;

  wire hold_done = (hold_cnt_ff >= 16'(RESET_HOLD_CYC - 1));
  wire in_reset = (state_ff != CRSD_ST_RUN);
  wire release_now = (state_ff == CRSD_ST_HOLD) && !cfg_rst_s && hold_done;
  // Leaving run clears the ratios on the same edge the pull-ups come back on
  wire leave_run = (state_ff == CRSD_ST_RUN) && cfg_rst_s;

  // Straps must settle a minimum time before release is honoured
  always_comb begin
    nxt_state = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    unique case (state_ff)
      CRSD_ST_RESET: begin
        nxt_state = CRSD_ST_HOLD;
        nxt_hold_cnt = '0;
      end
      CRSD_ST_HOLD: begin
        if (!hold_done) begin
          nxt_hold_cnt = hold_cnt_ff + 16'h0001;
        end
        if (release_now) begin
          nxt_state = CRSD_ST_RUN;
        end
      end
      CRSD_ST_RUN: begin
        if (cfg_rst_s) begin
          nxt_state = CRSD_ST_RESET;
        end
      end
      default: nxt_state = CRSD_ST_RESET; // Unused code falls back to reset
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= CRSD_ST_RESET;
      hold_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  // Sample straps continuously while in reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      plat_ff <= '0;
      core_ff <= '0;
      pci_ff <= 1'b1;
    end else if (in_reset) begin
      plat_ff <= plat_s;
      core_ff <= core_s;
      pci_ff <= pci_s;
    end
  end

  // Decoded values frozen at release; valid never overlaps the reset state
  always_ff @(posedge clock_i) begin
    if (rst_i || leave_run) begin
      latched_ff <= 1'b0;
      plat_mult_ff <= '0;
      core_halves_ff <= '0;
      pci64_ff <= 1'b0;
    end else if (release_now) begin
      latched_ff <= 1'b1;
      plat_mult_ff <= plat_decode(plat_ff);
      core_halves_ff <= core_decode(core_ff);
      pci64_ff <= ~pci_ff;
    end
  end

  // ****************************************
  // Clock ratio outputs
  // ****************************************

  wire plat_ok = (plat_mult_ff != `CRSD_PLAT_RESERVED);
  assign platform_mult_o = plat_mult_ff;
  assign core_halves_o = core_halves_ff;
  // One platform clock feeds all three domains
  assign l2_mult_o = plat_mult_ff;
  assign ddr_rate_mult_o = plat_mult_ff;
  assign ccb_mult_o = plat_mult_ff;
  // Doubled form keeps the half ratio an integer
  assign mem_bus_mult_x2_o = {1'b0, plat_mult_ff};
  assign pci64_o = pci64_ff;
  assign ratio_valid_o = latched_ff && plat_ok;

  // Pull-ups and reset-driven pin follow the reset state
  assign cfg_pullup_en_o = in_reset;
  assign reset_drive_en_o = 1'b1;
  assign reset_drive_o = in_reset;

  // ****************************************
  // Avalon-MM slave
  // ****************************************

  logic [31:0] ctrl_ff;
  logic [31:0] rdata_ff;
  logic ack_ff;
  wire req = (avs_read || avs_write) && !ack_ff;
  wire sel_ctrl = (avs_address == `CRSD_REG_CTRL);
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [31:0] core_eff = ctrl_ff[`CRSD_CORE_HALVES_BIT] ?
                         {29'h0, core_halves_ff} : {30'h0, core_halves_ff[1:0]};
  logic [31:0] rmux;

  // Unmapped reads return zero; writes elsewhere are ignored
  always_comb begin
    unique case (avs_address)
      `CRSD_REG_RATIO: rmux = {16'h0, core_eff[7:0], 3'h0, plat_mult_ff};
      `CRSD_REG_CTRL: rmux = ctrl_ff;
      `CRSD_REG_STATUS: rmux = {28'h0, in_reset, pci64_ff, latched_ff && !plat_ok, latched_ff};
      `CRSD_REG_STRAPS: rmux = {24'h0, pci_ff, core_ff, 1'b0, plat_ff};
      default: rmux = 32'h0000_0000;
    endcase
  end

  // One wait cycle per access
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
      ctrl_ff <= `CRSD_CTRL_RESET;
    end else begin
      ack_ff <= req;
      if (req && avs_read) begin
        rdata_ff <= rmux;
      end
      if (req && avs_write && sel_ctrl) begin
        ctrl_ff <= (ctrl_ff & ~be_mask) | (avs_writedata & be_mask & 32'h0000_0001);
      end
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign avs_readdata = rdata_ff;
endmodule

// ===== testbench/crsd_sva.sv
// Port assertions for the clock ratio strap decoder
`timescale 1ns/1ps
module crsd_sva (
  input wire logic clock_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cfg_reset_i, // Device reset
  input wire logic cfg_pullup_en_o, // Pull-up enable
  input wire logic reset_drive_en_o, // Drive enable
  input wire logic [4:0] platform_mult_o, // Platform ratio
  input wire logic [2:0] core_halves_o, // Core ratio
  input wire logic [4:0] l2_mult_o, // L2 ratio
  input wire logic [4:0] ddr_rate_mult_o, // DDR ratio
  input wire logic [4:0] ccb_mult_o, // Bus ratio
  input wire logic [5:0] mem_bus_mult_x2_o, // Memory ratio
  input wire logic pci64_o, // Wide PCI
  input wire logic ratio_valid_o, // Ratios good
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic avs_waitrequest // Wait
);
  // ****
  // Checks
  // ****
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence s_held;
    cfg_reset_i [*4];
  endsequence
  a_pullup_in_reset: assert property (s_held |-> cfg_pullup_en_o) else $error("pullup off");
  a_pullup_off_run: assert property (ratio_valid_o |-> !cfg_pullup_en_o) else $error("pullup on");
  a_drive_always_on: assert property (reset_drive_en_o) else $error("drive off");
  a_clock_tree_same: assert property (l2_mult_o == platform_mult_o && ddr_rate_mult_o ==
    platform_mult_o && ccb_mult_o == platform_mult_o) else $error("tree split");
  a_mem_bus_half: assert property (mem_bus_mult_x2_o == {1'b0, platform_mult_o})
    else $error("mem ratio");
  // Low now and two cycles back; outputs land on the same edge the pull-up drops
  a_ratio_held: assert property (!cfg_pullup_en_o && !$past(cfg_pullup_en_o, 2) |->
    $stable(platform_mult_o) && $stable(core_halves_o) && $stable(pci64_o))
    else $error("ratio moved");
  a_core_code_legal: assert property (ratio_valid_o |-> core_halves_o >= 3'h4)
    else $error("core code");
  a_plat_code_legal: assert property (ratio_valid_o |-> platform_mult_o inside
    {5'h10, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0c})
    else $error("plat code");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
endmodule
bind crsd_top crsd_sva crsd_sva_inst (.*);

// ===== testbench/crsd_board.sv
// Board reset logic and strap resistors
`timescale 1ns/1ps
module crsd_board (
  input wire logic clock_i, // Clock
  output logic cfg_reset_o, // Device reset
  output logic [3:0] plat_o, // Platform strap
  output logic [1:0] core_o, // Core strap
  output logic pci_o // PCI width strap
);
  // ****
  // Reset cycle
  // ****
  initial begin
    cfg_reset_o = 1'b1;
    plat_o = 4'h0;
    core_o = 2'h0;
    pci_o = 1'b1;
  end
  // Every strap is driven; after release the straps flip, as other traffic would
  task automatic power_cycle(input logic [3:0] p, input logic [1:0] c, input logic w);
    @(posedge clock_i);
    cfg_reset_o <= 1'b1;
    plat_o <= p;
    core_o <= c;
    pci_o <= !w;
    repeat (8) @(posedge clock_i);
    cfg_reset_o <= 1'b0;
    repeat (20) @(posedge clock_i);
    plat_o <= ~p;
    core_o <= ~c;
    pci_o <= w;
    repeat (3) @(posedge clock_i);
  endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench for the clock ratio strap decoder
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0, rst_i, cfg_reset_i, pci_width_strap_i, avs_read, avs_write;
  logic [3:0] platform_ratio_strap_i, avs_address, avs_byteenable;
  logic [1:0] core, c;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic cfg_pullup_en_o, reset_drive_en_o, reset_drive_o, pci64_o, ratio_valid_o, avs_waitrequest;
  logic [4:0] platform_mult_o, l2_mult_o, ddr_rate_mult_o, ccb_mult_o, pl;
  logic [2:0] core_halves_o;
  logic [5:0] mem_bus_mult_x2_o;
  int n_fail = 0, num_checks = 0;
  // ****
  // Harness
  // ****
  always #50 clock_i = ~clock_i;
  crsd_board crsd_board_inst (.clock_i(clock_i), .cfg_reset_o(cfg_reset_i),
    .plat_o(platform_ratio_strap_i), .core_o(core), .pci_o(pci_width_strap_i));
  // Short hold count keeps each power cycle brief
  crsd_top #(.RESET_HOLD_CYC(2)) crsd_top_inst (.*, .core_ratio_strap_high_i(core[1]),
    .core_ratio_strap_low_i(core[0]));
  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // Held until a rising edge samples waitrequest low; data taken and released there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge clock_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge clock_i);
    while (avs_waitrequest !== 1'b0) begin
      k++;
      if (k > 20) begin
        n_fail++;
        wrap_up();
      end
      @(posedge clock_i);
    end
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  function automatic logic [4:0] exp_plat(input logic [3:0] s);
    case (s)
      4'h0: return 5'h10;
      4'h1, 4'h7, 4'hb, 4'hd, 4'he, 4'hf: return 5'h00;
      default: return {1'b0, s};
    endcase
  endfunction
  // ****
  // Sequence
  // ****
  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    wrap_up();
  end
  initial begin
    rst_i = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    // Every platform code, every core code, both bus widths
    for (int i = 0; i < 16; i++) begin
      c = i[1:0];
      pl = exp_plat(i[3:0]);
      crsd_board_inst.power_cycle(i[3:0], c, i[0]);
      chk("plat", pl, platform_mult_o);
      chk("core", 3'h4 + c, core_halves_o);
      chk("pci64", i[0], pci64_o);
      chk("valid", pl != 5'h0, ratio_valid_o);
      chk("pullup", 0, cfg_pullup_en_o);
      chk("mem", {1'b0, pl}, mem_bus_mult_x2_o);
      chk("ccb", pl, ccb_mult_o);
      chk("l2", pl, l2_mult_o);
      chk("ddr", pl, ddr_rate_mult_o);
      chk("drive", 0, reset_drive_o);
      bus(1'b0, 4'hc, 0);
      chk("straps", {!i[0], c, 1'b0, i[3:0]}, d);
      bus(1'b1, 4'h4, i[2]);
      bus(1'b0, 4'h4, 0);
      chk("ctrl", i[2], d);
      bus(1'b0, 4'h0, 0);
      chk("ratio", {21'h0, i[2] ? 3'h4 + c : {1'b0, c}, 3'h0, pl}, d);
      bus(1'b0, 4'h8, 0);
      chk("status", {i[0], pl == 5'h0, 1'b1}, d);
    end
    bus(1'b1, 4'h0, 32'hffffffff);
    bus(1'b0, 4'h0, 0);
    chk("ratio ro", 32'h700, d);
    bus(1'b0, 4'h2, 0);
    chk("unmapped", 0, d);
    rst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk("plat rst", 0, platform_mult_o);
    chk("pullup rst", 1, cfg_pullup_en_o);
    chk("drive rst", 1, reset_drive_o);
    chk("drive en", 1, reset_drive_en_o);
    wrap_up();
  end
endmodule
